// File: pkg/pmc_pkg.sv
// Purpose: Shared constants and state encodings for the power sequencer
// Assumes: 10 MHz clock, comparator and command inputs synchronous to it
// Notes:   Times kept in their own unit, cycle counts derived here
package pmc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;
  // Regulator settling before the processor reset is released
  localparam int unsigned SETTLE_NS     = 1000000;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Constant-current target for the slim polymer pack
  localparam int unsigned CC_TARGET_W   = 9;
  localparam logic [CC_TARGET_W-1:0] CC_CURRENT_MA = 9'h12c;

  // Gray codes along off, check, wait-for-hold, held
  typedef enum logic [2:0] {
    PWR_OFF   = 3'h0,
    PWR_CHECK = 3'h1,
    PWR_WAIT  = 3'h3,
    PWR_HELD  = 3'h2,
    PWR_FAIL  = 3'h6
  } pmc_pwr_state_t;

  typedef enum logic [1:0] {
    CHG_IDLE    = 2'h0,
    CHG_TRICKLE = 2'h1,
    CHG_CC      = 2'h3,
    CHG_CV      = 2'h2
  } pmc_chg_state_t;

endpackage

// File: rtl/pmc_settle_timer.sv
// Purpose: Counts regulator settling time while the regulators are on
// Assumes: run stays high for the whole settling interval
// Notes:   done_q stays high until run drops
module pmc_settle_timer #(
  parameter int unsigned CYCLES = pmc_pkg::SETTLE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      done_q
);

  localparam int unsigned W = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } pmc_tmr_t;

  pmc_tmr_t t_q;
  pmc_tmr_t t_d;

  always_comb begin
    t_d = t_q;
    if (!run) begin
      t_d.cnt  = '0;
      t_d.done = 1'b0;
    end else if (t_q.cnt == W'(CYCLES)) begin
      t_d.done = 1'b1;
    end else begin
      t_d.cnt = t_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign done_q = t_q.done;

endmodule

// File: rtl/pmc_power_sequencer.sv
// Purpose: Power on/off sequencing and charge phase control
// Assumes: Battery, charger and fault comparators arrive as synchronous levels
// Notes:   Hold and shutdown arrive as one-cycle pulses from the serial decoder
// Functional notes
// - Key press: check battery, enable regulators
// - Regulators stay on after release once held
// - Connector start runs same check and power-up
// - Charger arrival powers up above 3.3V
// - Low battery charger start: trickle, then power
// - Alarm rise starts same check and power-up
// - Shutdown command switches regulators off
// - Charger arrival starts charge control, checks battery
// - Low battery: built-in trickle current only
// - In-limit battery: drive external pass transistor
// - Constant current first, then constant voltage
// - Current below threshold in CV: report full
// - Over-voltage/current cut pass; over-voltage powers down
// - Battery out of limits: reset low, regulators off
// - Reset held low until regulators settle
module pmc_power_sequencer #(
  parameter int unsigned SETTLE_CYCLES = pmc_pkg::SETTLE_CYCLES
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           key_power_on_input_n,
  input  wire logic                           connector_power_on_input_n,
  input  wire logic                           alarm_power_on_input,
  input  wire logic                           battery_in_limits,
  input  wire logic                           charger_present,
  input  wire logic                           battery_cv_reached,
  input  wire logic                           charge_current_low,
  input  wire logic                           over_voltage,
  input  wire logic                           over_current,
  input  wire logic                           hold_cmd,
  input  wire logic                           shutdown_cmd,
  output logic                                regulators_en,
  output logic                                serial_if_en,
  output logic                                power_fail_reset_n,
  output logic                                charge_drive_output,
  output logic                                trickle_en,
  output logic                                charge_cv_mode,
  output logic                                charge_full,
  output logic [pmc_pkg::CC_TARGET_W-1:0]     charge_current_target,
  output pmc_pkg::pmc_pwr_state_t             pwr_state
);

  typedef struct packed {
    pmc_pkg::pmc_pwr_state_t          pwr;
    pmc_pkg::pmc_chg_state_t          chg;
    logic                             start_prev;
    logic                             reg_en;
    logic                             rst_n;
    logic                             pass_en;
    logic                             trickle;
    logic                             full;
    logic                             fault;
    logic                             cv_mode;
    logic [pmc_pkg::CC_TARGET_W-1:0]  target;
  } pmc_state_t;

  localparam pmc_state_t S_RST = '{pwr: pmc_pkg::PWR_OFF, chg: pmc_pkg::CHG_IDLE, default: '0};

  pmc_state_t s_q;
  pmc_state_t s_d;
  logic       settled;
  logic       start_any;
  logic       start_rise;
  logic       ov_stop;
  logic       chg_fault;

  pmc_settle_timer #(
    .CYCLES (SETTLE_CYCLES)
  ) u_settle (
    .clk    (clk),
    .rst    (rst),
    .run    (s_q.reg_en),
    .done_q (settled)
  );

  // Connector input is already gated by service mode outside the chip
  assign start_any  = !key_power_on_input_n || !connector_power_on_input_n ||
                      alarm_power_on_input || charger_present;
  // Edge start: a key still held after shutdown does not restart
  assign start_rise = start_any && !s_q.start_prev;
  assign ov_stop    = charger_present && over_voltage;
  assign chg_fault  = charger_present && (s_q.fault || over_voltage || over_current);

  always_comb begin
    s_d = s_q;
    s_d.start_prev = start_any;

    unique case (s_q.pwr)
      pmc_pkg::PWR_OFF: begin
        if (start_rise && !ov_stop) begin
          s_d.pwr = pmc_pkg::PWR_CHECK;
        end
      end
      pmc_pkg::PWR_CHECK: begin
        if (ov_stop) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end else if (battery_in_limits) begin
          s_d.pwr = pmc_pkg::PWR_WAIT;
        end else if (!charger_present) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end
        // Low battery with charger: wait here while trickling
      end
      pmc_pkg::PWR_WAIT: begin
        if (ov_stop) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end else if (!battery_in_limits) begin
          s_d.pwr = pmc_pkg::PWR_FAIL;
        end else if (shutdown_cmd) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end else if (hold_cmd) begin
          s_d.pwr = pmc_pkg::PWR_HELD;
        end else if (!start_any) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end
      end
      pmc_pkg::PWR_HELD: begin
        if (ov_stop) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end else if (!battery_in_limits) begin
          s_d.pwr = pmc_pkg::PWR_FAIL;
        end else if (shutdown_cmd) begin
          s_d.pwr = pmc_pkg::PWR_OFF;
        end
      end
      pmc_pkg::PWR_FAIL: begin
        // One cycle with reset low before the regulators drop
        s_d.pwr = pmc_pkg::PWR_OFF;
      end
      default: begin
        s_d.pwr = pmc_pkg::PWR_OFF;
      end
    endcase

    s_d.reg_en = (s_d.pwr == pmc_pkg::PWR_WAIT) || (s_d.pwr == pmc_pkg::PWR_HELD) ||
                 (s_d.pwr == pmc_pkg::PWR_FAIL);
    s_d.rst_n  = settled && ((s_d.pwr == pmc_pkg::PWR_WAIT) || (s_d.pwr == pmc_pkg::PWR_HELD));

    // Fault latches until the charger is removed, so a flapping limit cannot pulse the pass device
    s_d.fault = chg_fault;
    if (!charger_present) begin
      s_d.chg  = pmc_pkg::CHG_IDLE;
      s_d.full = 1'b0;
    end else begin
      unique case (s_q.chg)
        pmc_pkg::CHG_IDLE: begin
          s_d.chg = battery_in_limits ? pmc_pkg::CHG_CC : pmc_pkg::CHG_TRICKLE;
        end
        pmc_pkg::CHG_TRICKLE: begin
          if (battery_in_limits) begin
            s_d.chg = pmc_pkg::CHG_CC;
          end
        end
        pmc_pkg::CHG_CC: begin
          if (battery_cv_reached) begin
            s_d.chg = pmc_pkg::CHG_CV;
          end
        end
        pmc_pkg::CHG_CV: begin
          if (charge_current_low) begin
            s_d.full = 1'b1;
          end
        end
      endcase
    end
    s_d.trickle = charger_present && !s_d.fault && (s_d.chg == pmc_pkg::CHG_TRICKLE);
    s_d.pass_en = charger_present && !s_d.fault &&
                  ((s_d.chg == pmc_pkg::CHG_CC) || (s_d.chg == pmc_pkg::CHG_CV));
    s_d.target  = (s_d.pass_en && (s_d.chg == pmc_pkg::CHG_CC)) ? pmc_pkg::CC_CURRENT_MA : '0;
    // Registered so the phase output comes straight from a flop
    s_d.cv_mode = s_d.pass_en && (s_d.chg == pmc_pkg::CHG_CV);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign regulators_en         = s_q.reg_en;
  assign serial_if_en          = s_q.reg_en;
  assign power_fail_reset_n    = s_q.rst_n;
  assign charge_drive_output   = s_q.pass_en;
  assign trickle_en            = s_q.trickle;
  assign charge_cv_mode        = s_q.cv_mode;
  assign charge_full           = s_q.full;
  assign charge_current_target = s_q.target;
  assign pwr_state             = s_q.pwr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_start_to_check: assert property (
    (s_q.pwr == pmc_pkg::PWR_OFF && start_rise && !ov_stop) |=> (s_q.pwr == pmc_pkg::PWR_CHECK) && !regulators_en)
    else $error("start edge did not enter check");
  a_check_powers_up: assert property (
    (s_q.pwr == pmc_pkg::PWR_CHECK && battery_in_limits && !ov_stop) |=> regulators_en && serial_if_en)
    else $error("good battery did not power up");
  a_hold_keeps_on: assert property (
    (s_q.pwr == pmc_pkg::PWR_HELD && !start_any && battery_in_limits && !shutdown_cmd && !ov_stop)
      |=> regulators_en && (pwr_state == pmc_pkg::PWR_HELD))
    else $error("held supply dropped on release");
  a_early_release: assert property (
    (s_q.pwr == pmc_pkg::PWR_WAIT && !start_any && !hold_cmd && battery_in_limits && !ov_stop)
      |=> !regulators_en && (s_q.pwr == pmc_pkg::PWR_OFF))
    else $error("release before hold kept supply on");
  a_shutdown_off: assert property (
    (s_q.pwr == pmc_pkg::PWR_HELD && shutdown_cmd && battery_in_limits) |=> !regulators_en)
    else $error("shutdown command ignored");
  a_low_trickle: assert property (
    (charger_present && s_q.chg == pmc_pkg::CHG_IDLE && !battery_in_limits && !chg_fault)
      |=> trickle_en && !charge_drive_output)
    else $error("low battery not trickle charged");
  a_cc_then_cv: assert property (
    (charger_present && s_q.chg == pmc_pkg::CHG_CC && battery_cv_reached && !chg_fault)
      |-> (charge_current_target == pmc_pkg::CC_CURRENT_MA) ##1 charge_cv_mode)
    else $error("no change from constant current to voltage");
  a_full_flag: assert property (
    (charger_present && s_q.chg == pmc_pkg::CHG_CV && charge_current_low) |=> charge_full)
    else $error("full not reported");
  a_fault_cut: assert property (
    (charger_present && (over_voltage || over_current)) |=> !charge_drive_output && !trickle_en)
    else $error("pass device not cut on fault");
  a_fail_order: assert property (
    (s_q.pwr == pmc_pkg::PWR_HELD && !battery_in_limits && !ov_stop)
      |=> (!power_fail_reset_n && regulators_en) ##1 !regulators_en)
    else $error("battery fail sequence wrong");
  a_reset_settle: assert property (
    $rose(power_fail_reset_n) |-> $past(settled) && regulators_en)
    else $error("reset released before settling");

endmodule

// File: dv/pmc_bb_model.sv
// Purpose: Baseband processor model issuing hold and shutdown commands
// Assumes: Commands are one-cycle pulses launched on the falling edge
// Notes:   Silent while held in reset, as it has no power then
module pmc_bb_model (
  input  wire logic       clk,
  input  wire logic       power_fail_reset_n,
  input  wire logic       keyboard_row_zero,
  input  wire logic       hold_en,
  input  wire logic [3:0] hold_wait,
  output logic            hold_cmd,
  output logic            shutdown_cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  bit held = 1'b0;
  bit shut = 1'b0;
  initial begin
    hold_cmd = 1'b0;
    shutdown_cmd = 1'b0;
  end
  always @(negedge clk) begin
    hold_cmd <= 1'b0;
    shutdown_cmd <= 1'b0;
    if (power_fail_reset_n !== 1'b1) begin
      cnt <= 0;
      held <= 1'b0;
      shut <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      // Slow answers exercise the waiting state
      if (hold_en && !held && cnt >= hold_wait) begin
        hold_cmd <= 1'b1;
        held <= 1'b1;
      end
      if (!keyboard_row_zero && !shut) begin
        shutdown_cmd <= 1'b1;
        shut <= 1'b1;
      end
      if (keyboard_row_zero) begin
        shut <= 1'b0;
      end
    end
  end
endmodule

// File: dv/pmc_power_sequencer_tb_top.sv
// Purpose: Self-checking bench for the power sequencer
// Assumes: Inputs change on the falling edge
// Notes:   Settling count shortened to keep the run brief
module pmc_power_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned ST = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic key_n = 1'b1, conn_n = 1'b1, alarm = 1'b0, batt = 1'b1, chg = 1'b0;
  logic cv = 1'b0, cur_low = 1'b0, ov = 1'b0, oc = 1'b0, krow = 1'b1, hold_en = 1'b1;
  logic [3:0] hold_wait = 4'h0;
  logic hold, shut, regs, sif, rstn, drv, trk, cvm, full;
  logic [8:0] tgt;
  pmc_pkg::pmc_pwr_state_t pwr;
  int error_cnt = 0;
  int n_tests = 0;

  always #50 clk = ~clk;

  pmc_power_sequencer #(.SETTLE_CYCLES(ST)) u_pmc_power_sequencer (
    .clk(clk), .rst(rst), .key_power_on_input_n(key_n), .connector_power_on_input_n(conn_n),
    .alarm_power_on_input(alarm), .battery_in_limits(batt), .charger_present(chg),
    .battery_cv_reached(cv), .charge_current_low(cur_low), .over_voltage(ov), .over_current(oc),
    .hold_cmd(hold), .shutdown_cmd(shut), .regulators_en(regs), .serial_if_en(sif),
    .power_fail_reset_n(rstn), .charge_drive_output(drv), .trickle_en(trk), .charge_cv_mode(cvm),
    .charge_full(full), .charge_current_target(tgt), .pwr_state(pwr));

  pmc_bb_model u_pmc_bb_model (
    .clk(clk), .power_fail_reset_n(rstn), .keyboard_row_zero(krow), .hold_en(hold_en),
    .hold_wait(hold_wait), .hold_cmd(hold), .shutdown_cmd(shut));

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait, a hang ends the run
  task automatic wait_st(input pmc_pkg::pmc_pwr_state_t s);
    for (int i = 0; i < 200 && pwr !== s; i++) @(negedge clk);
    if (pwr !== s) begin
      error_cnt++;
      $display("ERROR %0t: state wait timed out", $time);
      report_and_stop();
    end
  endtask

  task automatic set_src(input int s, input logic on);
    case (s)
      0: key_n = !on;
      1: conn_n = !on;
      default: alarm = on;
    endcase
  endtask

  task automatic start(input int s);
    set_src(s, 1'b1);
    tick(1);
    chk(pwr, pmc_pkg::PWR_CHECK);
    tick(1);
    chk(pwr, pmc_pkg::PWR_WAIT);
    chk({regs, sif, rstn}, 3'b110);
    tick(ST + 1);
    chk(rstn, 1'b0);
    tick(1);
    chk(rstn, 1'b1);
  endtask

  task automatic power_off;
    krow = 1'b0;
    wait_st(pmc_pkg::PWR_OFF);
    chk({regs, rstn}, 2'b00);
    krow = 1'b1;
    tick(1);
  endtask

  initial begin
    tick(8);
    chk({pwr, regs, rstn, drv, trk, full}, 8'h00);
    rst = 1'b0;
    for (int s = 0; s < 3; s++) begin
      hold_wait = 4'(s * 3);
      start(s);
      wait_st(pmc_pkg::PWR_HELD);
      set_src(s, 1'b0);
      tick(3);
      chk({pwr, regs}, {pmc_pkg::PWR_HELD, 1'b1});
      power_off();
    end
    // No hold before release drops power
    hold_en = 1'b0;
    start(0);
    set_src(0, 1'b0);
    tick(1);
    chk({pwr, regs}, 4'h0);
    hold_en = 1'b1;
    batt = 1'b0;
    set_src(0, 1'b1);
    tick(2);
    chk({pwr, regs}, 4'h0);
    set_src(0, 1'b0);
    batt = 1'b1;
    // Let the start level fall, else the alarm is no new edge
    tick(1);
    start(2);
    wait_st(pmc_pkg::PWR_HELD);
    set_src(2, 1'b0);
    batt = 1'b0;
    tick(1);
    chk({pwr, regs, rstn}, {pmc_pkg::PWR_FAIL, 2'b10});
    tick(1);
    chk({pwr, regs}, 4'h0);
    chg = 1'b1;
    tick(2);
    chk({pwr, trk, drv}, {pmc_pkg::PWR_CHECK, 2'b10});
    batt = 1'b1;
    tick(1);
    chk({pwr, regs, trk, drv}, {pmc_pkg::PWR_WAIT, 3'b101});
    chk(tgt, pmc_pkg::CC_CURRENT_MA);
    wait_st(pmc_pkg::PWR_HELD);
    cv = 1'b1;
    tick(1);
    chk(cvm, 1'b1);
    chk(tgt, 9'h000);
    cur_low = 1'b1;
    tick(1);
    chk(full, 1'b1);
    oc = 1'b1;
    tick(1);
    chk({drv, trk, regs}, 3'b001);
    {oc, chg, cv, cur_low} = 4'h0;
    tick(1);
    chk({full, cvm, drv}, 3'b000);
    chg = 1'b1;
    tick(2);
    ov = 1'b1;
    tick(1);
    chk({pwr, regs, rstn, drv}, 6'h00);
    {ov, chg} = 2'b00;
    tick(2);
    report_and_stop();
  end
endmodule
